/* File: verilog/gpio_port_pkg.sv */
// Package with register map and field layout of the four-pin open-drain port
package gpio_port_pkg;
  localparam logic [7:0] PIN_CONFIG_OFS    = 8'h10;
  localparam logic [7:0] PIN_EVENT_OFS     = 8'h0F;
  localparam logic [7:0] PIN_CONFIG_RST    = 8'h00;
  localparam logic [7:0] PIN_EVENT_RST     = 8'h00;
  localparam int         PIN_COUNT         = 4;
  localparam int         DIR_LSB           = 4;
  localparam int         VAL_LSB           = 0;
  localparam int         EDGE_LSB          = 4;
  localparam int         MASK_LSB          = 0;
endpackage

/* File: verilog/pin_sync.sv */
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
    if (srst_i)
    begin
      meta_nxt = '1;
      sync_nxt = '1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_o = sync_r;
endmodule // pin_sync

/* File: verilog/gpio_port.sv */
// Four-pin open-drain port with its configuration and event registers
// Operation
// - Upper four config bits set direction: 0 input, 1 output.
// - Output pin with value 1 turns pull-down on, pin low.
// - Output pin with value 0 releases pin to external pull-up.
// - Input pin value bit reads sampled pin level.
// - Writes to value bits of input pins are ignored.
// - Config register at offset 10h, resets to 00h.
// - Event polarity bit per pin: 0 falling, 1 rising edge.
// - Event mask bit per pin suppresses event; reset unmasked.
`timescale 1ns/10ps
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int NPINS = PIN_COUNT
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  input  wire logic [NPINS-1:0] pin_i,
  output logic      [NPINS-1:0] pin_o,
  output logic      [NPINS-1:0] pin_oe_o,
  output logic      [NPINS-1:0] pin_event_o
);
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] dir_nxt;
  logic [NPINS-1:0] val_r;
  logic [NPINS-1:0] val_nxt;
  logic [NPINS-1:0] edge_r;
  logic [NPINS-1:0] edge_nxt;
  logic [NPINS-1:0] mask_r;
  logic [NPINS-1:0] mask_nxt;
  logic [NPINS-1:0] pin_s;
  logic [NPINS-1:0] prev_r;
  logic [NPINS-1:0] prev_nxt;
  logic [NPINS-1:0] evt_r;
  logic [NPINS-1:0] evt_nxt;
  logic [NPINS-1:0] oe_r;
  logic [NPINS-1:0] oe_nxt;
  logic [NPINS-1:0] pin_r;
  logic [NPINS-1:0] pin_nxt;
  logic [7:0]       rdata_r;
  logic [7:0]       rdata_nxt;
  logic             cfg_wr;
  logic             evt_wr;

  pin_sync #(.WIDTH(NPINS)) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    (pin_i),
    .sync_o     (pin_s)
  );

  assign cfg_wr = reg_wr_i && (reg_addr_i == PIN_CONFIG_OFS);
  assign evt_wr = reg_wr_i && (reg_addr_i == PIN_EVENT_OFS);

  always_comb
  begin
    dir_nxt   = dir_r;
    val_nxt   = val_r;
    edge_nxt  = edge_r;
    mask_nxt  = mask_r;
    prev_nxt  = pin_s;
    rdata_nxt = rdata_r;
    if (cfg_wr)
    begin
      dir_nxt = reg_wdata_i[DIR_LSB +: NPINS];
    end
    if (evt_wr)
    begin
      edge_nxt = reg_wdata_i[EDGE_LSB +: NPINS];
      mask_nxt = reg_wdata_i[MASK_LSB +: NPINS];
    end
    for (int i = 0; i < NPINS; i++)
    begin
      if (!dir_nxt[i])
        val_nxt[i] = pin_s[i];
      else if (cfg_wr)
        val_nxt[i] = reg_wdata_i[VAL_LSB + i];
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == PIN_CONFIG_OFS)
        rdata_nxt = 8'({dir_r, val_r});
      else if (reg_addr_i == PIN_EVENT_OFS)
        rdata_nxt = 8'({edge_r, mask_r});
      else
        rdata_nxt = '0;
    end
    if (srst_i)
    begin
      dir_nxt   = PIN_CONFIG_RST[DIR_LSB +: NPINS];
      val_nxt   = PIN_CONFIG_RST[VAL_LSB +: NPINS];
      edge_nxt  = PIN_EVENT_RST[EDGE_LSB +: NPINS];
      mask_nxt  = PIN_EVENT_RST[MASK_LSB +: NPINS];
      prev_nxt  = '1;
      rdata_nxt = '0;
    end
  end

  always_comb
  begin
    pin_nxt = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      oe_nxt[i]  = dir_nxt[i] && val_nxt[i];
      evt_nxt[i] = !dir_r[i] && !mask_r[i] &&
                   (edge_r[i] ? (pin_s[i] && !prev_r[i]) : (!pin_s[i] && prev_r[i]));
    end
    if (srst_i)
    begin
      oe_nxt  = '0;
      evt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    dir_r   <= dir_nxt;
    val_r   <= val_nxt;
    edge_r  <= edge_nxt;
    mask_r  <= mask_nxt;
    prev_r  <= prev_nxt;
    rdata_r <= rdata_nxt;
    oe_r    <= oe_nxt;
    evt_r   <= evt_nxt;
    pin_r   <= pin_nxt;
  end

  assign reg_rdata_o = rdata_r;
  assign pin_o       = pin_r;
  assign pin_oe_o    = oe_r;
  assign pin_event_o = evt_r;

  a_pull_down_on: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ##1 (pin_oe_o == (dir_r & val_r))) else $error("pull-down not matching output config");

  a_input_no_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (dir_r == '0) |-> (pin_oe_o == '0)) else $error("input pin driven");

  a_dir_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cfg_wr |=> (dir_r == $past(reg_wdata_i[DIR_LSB +: NPINS]))) else $error("direction not taken");

  a_input_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!dir_nxt[0] && !$past(srst_i)) |=> (val_r[0] == $past(pin_s[0]))) else $error("input value not sampled");

  a_input_wr_ignored: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (cfg_wr && !reg_wdata_i[DIR_LSB] && (reg_wdata_i[VAL_LSB] != pin_s[0])) |=> (val_r[0] == $past(pin_s[0])))
    else $error("input value bit overwritten");

  a_reset_clear: assert property (@(posedge core_clk_i)
    srst_i |=> (dir_r == '0 && val_r == '0 && mask_r == '0)) else $error("reset value wrong");

  a_masked_silent: assert property (@(posedge core_clk_i) disable iff (srst_i)
    mask_r[0] |=> !pin_event_o[0]) else $error("masked pin raised event");

  a_rise_event: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!dir_r[0] && !mask_r[0] && edge_r[0] && pin_s[0] && !prev_r[0]) |=> pin_event_o[0])
    else $error("rising edge missed");

  a_sync_delay: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ##2 (pin_s == $past(pin_i, 2))) else $error("synchroniser depth wrong");

  a_pin_out_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ##1 (pin_o == '0))
    else $error("open-drain output value not low");

  a_config_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (reg_rd_i && (reg_addr_i == PIN_CONFIG_OFS)) |=> (reg_rdata_o == 8'($past({dir_r, val_r}))))
    else $error("config read data wrong");

  a_unmapped_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (reg_rd_i && (reg_addr_i != PIN_CONFIG_OFS) && (reg_addr_i != PIN_EVENT_OFS)) |=> (reg_rdata_o == '0))
    else $error("unmapped read not zero");

  // Per-pin checks of the open-drain and event paths
  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin_chk
    sequence s_rise_seen;
      !dir_r[g] && !mask_r[g] && edge_r[g] && pin_s[g] && !prev_r[g];
    endsequence

    sequence s_fall_seen;
      !dir_r[g] && !mask_r[g] && !edge_r[g] && !pin_s[g] && prev_r[g];
    endsequence

    a_rise_each: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_rise_seen |=> pin_event_o[g])
      else $error("rising edge event missed");

    a_fall_each: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_fall_seen |=> pin_event_o[g])
      else $error("falling edge event missed");

    a_wrong_edge: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (edge_r[g] && !(pin_s[g] && !prev_r[g])) |=> !pin_event_o[g])
      else $error("event on unselected edge");

    a_mask_each: assert property (@(posedge core_clk_i) disable iff (srst_i)
      mask_r[g] |=> !pin_event_o[g])
      else $error("masked pin raised event");

    a_output_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
      dir_r[g] |=> !pin_event_o[g])
      else $error("output pin raised event");

    a_release_each: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (dir_r[g] && !val_r[g]) |-> !pin_oe_o[g])
      else $error("released pin still pulled down");

    a_out_value_wr: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (cfg_wr && reg_wdata_i[DIR_LSB + g]) |=> (val_r[g] == $past(reg_wdata_i[VAL_LSB + g])))
      else $error("output value bit not taken");
  end
endmodule // gpio_port

/* File: tb/pullup_model.sv */
// External pull-ups and far-side drivers on the four port pins
`timescale 1ns/10ps
module pullup_model (
  input  wire logic [3:0] pin_oe_i,
  input  wire logic [3:0] ext_low_i,
  output logic      [3:0] level_o
);
  // Pin reads low when either side pulls down, else the pull-up wins
  assign level_o = ~(pin_oe_i | ext_low_i);
endmodule // pullup_model

/* File: tb/gpio_port_tb.sv */
// Self-checking bench for the open-drain port
`timescale 1ns/10ps
module gpio_port_tb;
  import gpio_port_pkg::*;
  logic        core_clk_i = 0;
  logic        srst_i = 1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic        reg_wr_i = 0;
  logic        reg_rd_i = 0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o, d, oe;
  logic [3:0]  lvl, pin_o, pin_oe_o, pin_event_o, ext = 4'h0;
  logic        rd_d = 0;
  logic [7:0]  exp_q[$];
  int          fail_count = 0, num_checks = 0, n;
  int unsigned seed = 18636;
  always #5 core_clk_i = ~core_clk_i;
  gpio_port DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_event_o(pin_event_o));
  pullup_model PU (.pin_oe_i(pin_oe_o), .ext_low_i(ext), .level_o(lvl));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  // Write when w is set, else read and note the expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = w;
    reg_rd_i = !w;
    if (!w) exp_q.push_back(v);
    @(negedge core_clk_i);
    reg_wr_i = 0;
    reg_rd_i = 0;
  endtask
  always @(posedge core_clk_i) rd_d <= reg_rd_i;
  always @(negedge core_clk_i)
    if (rd_d) check(reg_rdata_o, exp_q.pop_front());
  // Set event config, move all pins, count pulses
  task automatic evt(input logic [7:0] c, input logic [3:0] e, input int p);
    acc(1, PIN_EVENT_OFS, c);
    ext = e;
    n = 0;
    repeat (8)
    begin
      @(negedge core_clk_i);
      n += $countones(pin_event_o);
    end
    check(8'(n), 8'(p));
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(20);
    srst_i = 0;
    cyc(3);
    check({4'h0, pin_o}, 8'h00);
    acc(0, PIN_CONFIG_OFS, 8'h0F);
    acc(0, PIN_EVENT_OFS, PIN_EVENT_RST);
    acc(0, 8'h22, 8'h00);
    repeat (10)
    begin
      oe = rnd();
      ext = oe[3:0];
      d = rnd();
      acc(1, PIN_CONFIG_OFS, d);
      oe = {4'h0, d[7:4] & d[3:0]};
      check({4'h0, pin_oe_o}, oe);
      cyc(5);
      acc(0, PIN_CONFIG_OFS, {d[7:4], oe[3:0] | (~d[7:4] & ~(oe[3:0] | ext))});
    end
    acc(1, PIN_CONFIG_OFS, 8'h00);
    ext = 4'h0;
    cyc(6);
    acc(1, PIN_CONFIG_OFS, 8'hF5);
    srst_i = 1;
    cyc(3);
    srst_i = 0;
    cyc(3);
    check({4'h0, pin_oe_o}, 8'h00);
    acc(0, PIN_CONFIG_OFS, 8'h0F);
    evt(8'h00, 4'hF, 4);
    evt(8'hF0, 4'h0, 4);
    evt(8'hF0, 4'hF, 0);
    evt(8'hFF, 4'h0, 0);
    summarize();
  end
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule // gpio_port_tb
